/* File: rtl/cfbx_pkg.sv */
// Package of opcodes, status word layout and carriers for the flag and branch executor
// Summary of operation
// - Mask test ANDs operands, only flags change
// - Mask test: N=msb, Z=zero, C=!Z, V=0
// - Never touch oscillator, halt, interrupt enable bits
// - Jump loads destination into PC, flags kept
// - Call: push return address, then load PC
// - Call is word-only, any address, flags kept
// - Zeroing writes 0 to destination, flags kept
// - Carry clear clears only C
// - Negative clear masks status word with 0FFFBh
// - Zero clear masks status word with 0FFFDh
// - Compare adds inverted source plus one, discards
// - Compare sets N, Z, C, V from result
// - Decimal carry add adds C to destination decimally
// - Decimal carry add: N msb, Z zero, C rollover
// - Compare flags equal subtraction flags
// - Interrupt enable sits at status bit 3 (mask 08h)
package cfbx_pkg;

  typedef enum logic [3:0] {
    CFBX_OP_MASK_TEST = 4'h0,
    CFBX_OP_JUMP_ABS = 4'h1,
    CFBX_OP_CALL = 4'h2,
    CFBX_OP_ZERO_DEST = 4'h3,
    CFBX_OP_CARRY_ZERO = 4'h4,
    CFBX_OP_NEG_ZERO = 4'h5,
    CFBX_OP_ZFLAG_CLEAR = 4'h6,
    CFBX_OP_COMPARE = 4'h7,
    CFBX_OP_DEC_CARRY_ADD = 4'h8
  } cfbx_op_t;

  // Status word bit positions
  localparam int unsigned SW_C_BIT = 0;
  localparam int unsigned SW_Z_BIT = 1;
  localparam int unsigned SW_N_BIT = 2;
  localparam int unsigned SW_GIE_BIT = 3;
  localparam int unsigned SW_HALT_BIT = 4;
  localparam int unsigned SW_OSC_BIT = 5;
  localparam int unsigned SW_V_BIT = 8;

  localparam logic [15:0] SW_MASK_C = 16'h0001;
  localparam logic [15:0] SW_MASK_N_INV = 16'hFFFB;
  localparam logic [15:0] SW_MASK_Z_INV = 16'hFFFD;
  localparam logic [15:0] SW_MASK_GIE = 16'h0008;
  localparam logic [15:0] SP_STEP = 16'h0002;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [15:0] SW_RESET = 16'h0000;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam int unsigned BYTE_MSB = 7;
  localparam int unsigned WORD_MSB = 15;

  typedef struct packed {
    cfbx_op_t op;
    logic byte_mode;
    logic [15:0] src;
    logic [15:0] dst;
    logic [15:0] next_pc;
  } cfbx_req_t;

  typedef struct packed {
    logic dst_we;
    logic [15:0] dst_data;
    logic pc_we;
    logic [15:0] pc;
    logic stack_we;
    logic [15:0] stack_addr;
    logic [15:0] stack_data;
    logic [15:0] sp;
    logic [15:0] status;
  } cfbx_res_t;

endpackage : cfbx_pkg

/* File: rtl/cfbx_bcd_digit.sv */
// One BCD digit adder stage with decimal carry
module cfbx_bcd_digit (
  input wire logic [3:0] a_i, // Digit in
  input wire logic cin_i, // Carry in
  output logic [3:0] sum_o, // Digit out
  output logic cout_o // Decimal carry out
);
  logic [4:0] raw;
  logic [4:0] fix;

  always_comb begin
    raw = {1'b0, a_i} + {4'h0, cin_i};
    fix = raw + 5'h06;
    if (raw > 5'h09) begin
      sum_o = fix[3:0];
      cout_o = 1'b1;
    end else begin
      sum_o = raw[3:0];
      cout_o = 1'b0;
    end
  end
endmodule : cfbx_bcd_digit

/* File: rtl/cfbx_exec.sv */
// Execution unit for mask test, jumps, call, clears, compare and decimal carry add
module cfbx_exec (
  input wire logic CLK_I, // Core clock, 100 MHz
  input wire logic RST_N_I, // Async reset, active low
  input wire logic REQ_VALID_I, // Instruction issue strobe
  input wire cfbx_pkg::cfbx_req_t REQ_I, // Operation and operands
  input wire logic [15:0] STATUS_I, // Current status word
  input wire logic [15:0] SP_I, // Current stack pointer
  output logic DONE_O, // One-cycle completion pulse
  output cfbx_pkg::cfbx_res_t RES_O // Committed results
);

  // ==========================================================
  // Operand width handling
  logic byte_m;
  logic [15:0] src_w;
  logic [15:0] dst_w;
  logic [16:0] cmp_sum;
  logic [15:0] and_res;
  logic [15:0] cmp_res;
  logic [15:0] bcd_res;
  logic [4:0] bcd_cy;
  logic msb_and;
  logic msb_cmp;
  logic msb_bcd;
  logic cmp_carry;
  logic cmp_ovf;
  logic bcd_carry;
  logic [15:0] sw_cur;
  logic [15:0] sw_next;
  cfbx_pkg::cfbx_res_t res_next;

  always_comb begin
    byte_m = REQ_I.byte_mode;
    src_w = byte_m ? {8'h00, REQ_I.src[7:0]} : REQ_I.src;
    dst_w = byte_m ? {8'h00, REQ_I.dst[7:0]} : REQ_I.dst;
  end

  // ==========================================================
  // Arithmetic
  assign and_res = src_w & dst_w;
  // Subtraction as add of inverted source plus one
  assign cmp_sum = {1'b0, dst_w} + {1'b0, byte_m ? {8'h00, ~src_w[7:0]} : ~src_w}
    + 17'h0_0001;
  assign cmp_res = byte_m ? {8'h00, cmp_sum[7:0]} : cmp_sum[15:0];
  assign cmp_carry = byte_m ? cmp_sum[8] : cmp_sum[16];
  assign msb_and = byte_m ? and_res[cfbx_pkg::BYTE_MSB] : and_res[cfbx_pkg::WORD_MSB];
  assign msb_cmp = byte_m ? cmp_res[cfbx_pkg::BYTE_MSB] : cmp_res[cfbx_pkg::WORD_MSB];
  // Overflow only when operand signs differ and the result sign leaves the destination's
  assign cmp_ovf = byte_m
    ? (dst_w[cfbx_pkg::BYTE_MSB] != src_w[cfbx_pkg::BYTE_MSB])
      && (cmp_res[cfbx_pkg::BYTE_MSB] != dst_w[cfbx_pkg::BYTE_MSB])
    : (dst_w[cfbx_pkg::WORD_MSB] != src_w[cfbx_pkg::WORD_MSB])
      && (cmp_res[cfbx_pkg::WORD_MSB] != dst_w[cfbx_pkg::WORD_MSB]);

  // Decimal add of carry, digit chain; non-BCD input gives undefined-style result
  assign bcd_cy[0] = STATUS_I[cfbx_pkg::SW_C_BIT];
  genvar gd;
  generate
    for (gd = 0; gd < 4; gd++) begin : g_digit
      cfbx_bcd_digit u_digit (
        .a_i(dst_w[4*gd +: 4]),
        .cin_i(bcd_cy[gd]),
        .sum_o(bcd_res[4*gd +: 4]),
        .cout_o(bcd_cy[gd+1])
      );
    end
  endgenerate
  assign bcd_carry = byte_m ? bcd_cy[2] : bcd_cy[4];
  assign msb_bcd = byte_m ? bcd_res[cfbx_pkg::BYTE_MSB] : bcd_res[cfbx_pkg::WORD_MSB];

  // ==========================================================
  // Result selection
  always_comb begin
    sw_cur = STATUS_I;
    sw_next = sw_cur;
    res_next = '0;
    res_next.sp = SP_I;
    case (REQ_I.op)
      cfbx_pkg::CFBX_OP_MASK_TEST: begin
        sw_next[cfbx_pkg::SW_N_BIT] = msb_and;
        sw_next[cfbx_pkg::SW_Z_BIT] = (and_res == cfbx_pkg::WORD_ZERO);
        sw_next[cfbx_pkg::SW_C_BIT] = (and_res != cfbx_pkg::WORD_ZERO);
        sw_next[cfbx_pkg::SW_V_BIT] = 1'b0;
      end
      cfbx_pkg::CFBX_OP_JUMP_ABS: begin
        res_next.pc_we = 1'b1;
        res_next.pc = REQ_I.dst;
      end
      cfbx_pkg::CFBX_OP_CALL: begin
        // Target held from the request, so push cannot disturb it
        res_next.sp = SP_I - cfbx_pkg::SP_STEP;
        res_next.stack_we = 1'b1;
        res_next.stack_addr = SP_I - cfbx_pkg::SP_STEP;
        res_next.stack_data = REQ_I.next_pc;
        res_next.pc_we = 1'b1;
        res_next.pc = REQ_I.dst;
      end
      cfbx_pkg::CFBX_OP_ZERO_DEST: begin
        res_next.dst_we = 1'b1;
        res_next.dst_data = cfbx_pkg::WORD_ZERO;
      end
      cfbx_pkg::CFBX_OP_CARRY_ZERO: begin
        sw_next = sw_cur & ~cfbx_pkg::SW_MASK_C;
      end
      cfbx_pkg::CFBX_OP_NEG_ZERO: begin
        sw_next = sw_cur & cfbx_pkg::SW_MASK_N_INV;
      end
      cfbx_pkg::CFBX_OP_ZFLAG_CLEAR: begin
        sw_next = sw_cur & cfbx_pkg::SW_MASK_Z_INV;
      end
      cfbx_pkg::CFBX_OP_COMPARE: begin
        sw_next[cfbx_pkg::SW_N_BIT] = msb_cmp;
        sw_next[cfbx_pkg::SW_Z_BIT] = (cmp_res == cfbx_pkg::WORD_ZERO);
        sw_next[cfbx_pkg::SW_C_BIT] = cmp_carry;
        sw_next[cfbx_pkg::SW_V_BIT] = cmp_ovf;
      end
      cfbx_pkg::CFBX_OP_DEC_CARRY_ADD: begin
        res_next.dst_we = 1'b1;
        res_next.dst_data = byte_m ? {8'h00, bcd_res[7:0]} : bcd_res;
        sw_next[cfbx_pkg::SW_N_BIT] = msb_bcd;
        sw_next[cfbx_pkg::SW_Z_BIT] = byte_m ? (bcd_res[7:0] == 8'h00)
          : (bcd_res == cfbx_pkg::WORD_ZERO);
        sw_next[cfbx_pkg::SW_C_BIT] = bcd_carry;
      end
      default: begin
        sw_next = sw_cur;
      end
    endcase
    // Mode bits always pass through untouched
    sw_next[cfbx_pkg::SW_GIE_BIT] = sw_cur[cfbx_pkg::SW_GIE_BIT];
    sw_next[cfbx_pkg::SW_HALT_BIT] = sw_cur[cfbx_pkg::SW_HALT_BIT];
    sw_next[cfbx_pkg::SW_OSC_BIT] = sw_cur[cfbx_pkg::SW_OSC_BIT];
    res_next.status = sw_next;
  end

  // ==========================================================
  // Commit: all effects land on one edge
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      DONE_O <= 1'b0;
    end else begin
      DONE_O <= REQ_VALID_I;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RES_O <= '0;
      RES_O.status <= cfbx_pkg::SW_RESET;
      RES_O.sp <= cfbx_pkg::SP_RESET;
      RES_O.pc <= cfbx_pkg::PC_RESET;
    end else if (REQ_VALID_I) begin
      RES_O <= res_next;
    end else begin
      RES_O.dst_we <= 1'b0;
      RES_O.pc_we <= 1'b0;
      RES_O.stack_we <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  logic [15:0] sw_in_q;
  logic [15:0] sp_in_q;
  logic [15:0] dst_in_q;
  cfbx_pkg::cfbx_op_t op_q;
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sw_in_q <= 16'h0000;
      sp_in_q <= 16'h0000;
      dst_in_q <= 16'h0000;
      op_q <= cfbx_pkg::CFBX_OP_MASK_TEST;
    end else begin
      sw_in_q <= STATUS_I;
      sp_in_q <= SP_I;
      dst_in_q <= REQ_I.dst;
      op_q <= REQ_I.op;
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  chk_mode_bits_kept: assert property (
    DONE_O |-> ((RES_O.status ^ sw_in_q) & 16'h0038) == 16'h0000)
    else $error("Mode bits altered");
  chk_mask_test_flags: assert property (
    DONE_O && op_q == cfbx_pkg::CFBX_OP_MASK_TEST
    |-> RES_O.status[cfbx_pkg::SW_C_BIT] == !RES_O.status[cfbx_pkg::SW_Z_BIT]
    && !RES_O.status[cfbx_pkg::SW_V_BIT] && !RES_O.dst_we)
    else $error("Mask test flags wrong");
  chk_jump_target: assert property (
    REQ_VALID_I && REQ_I.op == cfbx_pkg::CFBX_OP_JUMP_ABS
    |=> RES_O.pc_we && RES_O.pc == dst_in_q && RES_O.status == sw_in_q)
    else $error("Jump wrong");
  chk_call_push: assert property (
    DONE_O && op_q == cfbx_pkg::CFBX_OP_CALL
    |-> RES_O.stack_we && RES_O.sp == sp_in_q - 16'h0002 && RES_O.stack_addr == RES_O.sp)
    else $error("Call push wrong");
  chk_call_flags: assert property (
    DONE_O && op_q == cfbx_pkg::CFBX_OP_CALL
    |-> RES_O.status == sw_in_q && RES_O.pc == dst_in_q)
    else $error("Call flags or PC wrong");
  chk_zero_dest: assert property (
    DONE_O && op_q == cfbx_pkg::CFBX_OP_ZERO_DEST
    |-> RES_O.dst_we && RES_O.dst_data == 16'h0000 && RES_O.status == sw_in_q)
    else $error("Zeroing wrong");
  chk_carry_clear: assert property (
    DONE_O && op_q == cfbx_pkg::CFBX_OP_CARRY_ZERO
    |-> RES_O.status == (sw_in_q & 16'hFFFE))
    else $error("Carry clear wrong");
  chk_neg_clear: assert property (
    DONE_O && op_q == cfbx_pkg::CFBX_OP_NEG_ZERO
    |-> RES_O.status == (sw_in_q & 16'hFFFB))
    else $error("Negative clear wrong");
  chk_zflag_clear: assert property (
    DONE_O && op_q == cfbx_pkg::CFBX_OP_ZFLAG_CLEAR
    |-> RES_O.status == (sw_in_q & 16'hFFFD))
    else $error("Zero clear wrong");
  chk_compare_nowrite: assert property (
    DONE_O && op_q == cfbx_pkg::CFBX_OP_COMPARE
    |-> !RES_O.dst_we && !RES_O.pc_we)
    else $error("Compare wrote");
  chk_done_pulse: assert property (
    REQ_VALID_I |=> DONE_O ##1 (DONE_O == $past(REQ_VALID_I)))
    else $error("Done timing wrong");

  cov_call: cover property (DONE_O && op_q == cfbx_pkg::CFBX_OP_CALL);
  cov_compare_eq: cover property (DONE_O && op_q == cfbx_pkg::CFBX_OP_COMPARE
    && RES_O.status[cfbx_pkg::SW_Z_BIT]);
  cov_bcd_roll: cover property (DONE_O && op_q == cfbx_pkg::CFBX_OP_DEC_CARRY_ADD
    && RES_O.status[cfbx_pkg::SW_C_BIT]);
  cov_back_to_back: cover property (REQ_VALID_I ##1 REQ_VALID_I);

endmodule : cfbx_exec

/* File: bench/tb_top.sv */
// Self-checking bench for the flag and branch executor
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  cfbx_pkg::cfbx_req_t req = '0;
  logic [15:0] status_in = 16'h0000;
  logic [15:0] sp_in = 16'h0000;
  logic done;
  cfbx_pkg::cfbx_res_t res;
  cfbx_pkg::cfbx_res_t exp_q[$];
  cfbx_pkg::cfbx_res_t e;
  logic taken_d = 1'b0;
  int error_cnt = 0;
  int check_count = 0;

  cfbx_exec uut (.CLK_I(clk), .RST_N_I(rst_n), .REQ_VALID_I(req_valid), .REQ_I(req),
    .STATUS_I(status_in), .SP_I(sp_in), .DONE_O(done), .RES_O(res));

  initial begin
    forever #5 clk = ~clk;
  end

  // ==========================================================
  // Reference model
  function automatic cfbx_pkg::cfbx_res_t model(input cfbx_pkg::cfbx_req_t q,
      input logic [15:0] st, input logic [15:0] sp);
    cfbx_pkg::cfbx_res_t r;
    int w, m, a, b, s, c, d;
    logic n, z, cy, v, upd;
    r = '0;
    r.status = st;
    w = q.byte_mode ? 8 : 16;
    m = (1 << w) - 1;
    a = q.src & m;
    b = q.dst & m;
    {n, z, cy, v} = {st[2], st[1], st[0], st[8]};
    upd = 1'b1;
    s = 0;
    case (q.op)
      cfbx_pkg::CFBX_OP_MASK_TEST: begin
        s = a & b;
        cy = (s != 0);
        v = 1'b0;
      end
      cfbx_pkg::CFBX_OP_COMPARE: begin
        s = b + (~a & m) + 1;
        cy = (s >> w) & 1;
        s = s & m;
        v = ((a >> (w - 1)) != (b >> (w - 1))) && ((s >> (w - 1)) != (b >> (w - 1)));
      end
      cfbx_pkg::CFBX_OP_DEC_CARRY_ADD: begin
        c = st[0];
        for (int i = 0; i < w / 4; i++) begin
          d = ((b >> (4 * i)) & 15) + c;
          c = (d > 9) ? 1 : 0;
          d = (d > 9) ? d - 10 : d;
          s = s | (d << (4 * i));
        end
        cy = c[0];
        r.dst_we = 1'b1;
        r.dst_data = 16'(s);
      end
      default: upd = 1'b0;
    endcase
    if (upd) begin
      n = ((s >> (w - 1)) & 1) != 0;
      z = (s == 0);
      r.status = {st[15:9], v, st[7:3], n, z, cy};
    end
    case (q.op)
      cfbx_pkg::CFBX_OP_JUMP_ABS: {r.pc_we, r.pc} = {1'b1, q.dst};
      cfbx_pkg::CFBX_OP_CALL: begin
        {r.pc_we, r.pc, r.stack_we, r.stack_data} = {1'b1, q.dst, 1'b1, q.next_pc};
        r.stack_addr = sp - 16'h0002;
        r.sp = sp - 16'h0002;
      end
      cfbx_pkg::CFBX_OP_ZERO_DEST: {r.dst_we, r.dst_data} = {1'b1, 16'h0000};
      cfbx_pkg::CFBX_OP_CARRY_ZERO: r.status = st & 16'hFFFE;
      cfbx_pkg::CFBX_OP_NEG_ZERO: r.status = st & 16'hFFFB;
      cfbx_pkg::CFBX_OP_ZFLAG_CLEAR: r.status = st & 16'hFFFD;
      default: ;
    endcase
    return r;
  endfunction : model

  task automatic chk(input bit ok, input string msg);
    check_count++;
    if (!ok) begin
      error_cnt++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk

  // ==========================================================
  // Expectations follow every accepted request by one cycle
  always @(posedge clk) begin
    taken_d <= rst_n && (req_valid === 1'b1);
    if (rst_n && req_valid === 1'b1) exp_q.push_back(model(req, status_in, sp_in));
  end

  always @(negedge clk) begin
    chk(done === taken_d, "done strobe");
    if (done === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      chk(res.status === e.status, "status");
      chk(res.dst_we === e.dst_we, "dest we");
      chk({res.pc_we, res.stack_we} === {e.pc_we, e.stack_we}, "pc and stack we");
      if (e.dst_we) chk(res.dst_data === e.dst_data, "dest data");
      if (e.pc_we) chk(res.pc === e.pc, "pc");
      if (e.stack_we) chk(res.stack_addr === e.stack_addr, "stack address");
      if (e.stack_we) chk({res.stack_data, res.sp} === {e.stack_data, e.sp}, "stack data");
    end else if (done !== 1'b1) begin
      chk({res.dst_we, res.pc_we, res.stack_we} === 3'b000, "idle we");
    end
  end

  // ==========================================================
  // Stimulus
  task automatic issue(input int op, input logic bm, input logic [15:0] src,
      input logic [15:0] dst, input logic [15:0] st);
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{cfbx_pkg::cfbx_op_t'(op[3:0]), bm, src, dst, 16'($urandom)};
    status_in <= st;
    sp_in <= 16'($urandom) & 16'hFFFE;
  endtask : issue

  task automatic idle;
    @(posedge clk);
    req_valid <= 1'b0;
  endtask : idle

  task give_verdict;
    $display("Comparisons %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    int op;
    logic [15:0] d;
    void'($urandom(32'h390c));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    issue(0, 1'b0, 16'h00F0, 16'h0F00, 16'hFFFF);
    issue(0, 1'b1, 16'h0080, 16'hFF80, 16'h0000);
    issue(7, 1'b0, 16'h0001, 16'h8000, 16'h0000);
    issue(7, 1'b1, 16'h0005, 16'h1205, 16'h0000);
    issue(8, 1'b0, 16'h0000, 16'h9999, 16'h0001);
    issue(8, 1'b1, 16'h0000, 16'h1299, 16'h0001);
    for (int k = 0; k < 9; k++) issue(k, 1'b0, 16'h1234, 16'h5678, 16'hFFFF);
    issue(15, 1'b0, 16'h1234, 16'h5678, 16'h0107);
    for (int k = 0; k < 300; k++) begin
      op = $urandom % 10;
      op = (op == 9) ? 15 : op;
      d = 16'($urandom);
      if (op == 8) d = {4'($urandom % 10), 4'($urandom % 10),
        4'($urandom % 10), 4'($urandom % 10)};
      issue(op, (op == 0 || op == 3 || op == 7 || op == 8) ? 1'($urandom) : 1'b0,
        16'($urandom), d, 16'($urandom));
      if ($urandom % 4 == 0) idle();
    end
    idle();
    idle();
    @(posedge clk);
    rst_n <= 1'b0;
    #1;
    chk(done === 1'b0 && res === cfbx_pkg::cfbx_res_t'(0), "reset clear");
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    issue(2, 1'b0, 16'h0000, 16'hFFFE, 16'h0000);
    idle();
    idle();
    give_verdict();
  end

  initial begin
    #50000;
    error_cnt++;
    give_verdict();
  end
endmodule : tb_top
